/* File: sxci_top.sv */
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns
// Behaviour
// - pause decelerates internal motion to stop
// - pause ignored under pulse-train command
// - finish program line before pausing
// - paused: execution suspended, busy stays closed
// - release resumes, motor reaccelerates
// - alarm or halt cancels pause, opens busy
// - start while paused: busy closes, stays held
// - override scales programmed velocity by ratio
// - override uses programmed accel profile
// - overridden velocity clamped to 10 rev/s
// - suppress limits integral and lowers gain
// - limiter zero cuts integral at once
// - no gain lowering during auto tuning
// - homing starts on rising edge only
// - absolute move after aborted homing warns
// - proximity input used in modes 1,3,4,5
// - per-input polarity, 1 means normally closed
module sxci_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pause_request,
    input wire logic speed_override_request,
    input wire logic integral_suppress,
    input wire logic homing_start,
    input wire logic home_proximity_sensor,
    input wire logic halt_request,
    input wire sxci_pkg::sxci_seq_type seq,
    input wire logic [15:0] programmed_velocity,
    output logic busy,
    output logic hold_decel,
    output logic exec_suspend,
    output logic resume_pulse,
    output logic [15:0] target_velocity,
    output logic [15:0] integral_ratio,
    output logic [15:0] gain_ratio,
    output logic homing_go,
    output logic [2:0] homing_mode_out,
    output logic home_near,
    output logic warn_origin_undefined,
    output logic irq
);
    import sxci_pkg::*;

    sxci_cfg_type cfg_q; // software settings
    logic [IN_W-1:0] sync1_q; // first stage, read only by stage two
    logic [IN_W-1:0] sync2_q; // settled pin levels
    logic [IN_W-1:0] act; // polarity-corrected levels
    logic hstart_prev_q; // for edge detection
    sxci_state_type state_q;
    sxci_state_type state_d;
    logic homed_q; // origin defined
    logic [EV_W-1:0] irq_stat_q;
    logic [EV_W-1:0] irq_mask_q;
    logic [EV_W-1:0] ev; // event pulses this cycle
    logic apb_acc; // access phase, first cycle
    logic apb_wr;
    logic apb_rd;
    logic [31:0] rd_d;
    logic hit;
    logic [31:0] vel_prod; // velocity times ratio
    logic [31:0] vel_scaled;
    logic mode_uses_prox;

    // two-flop synchroniser for all pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {halt_request, home_proximity_sensor, homing_start,
                integral_suppress, speed_override_request, pause_request};
            sync2_q <= sync1_q;
        end
    end

    // per-input polarity, normally closed inverts
    genvar gi;
    generate
        for (gi = 0; gi < IN_W; gi++) begin : g_pol
            assign act[gi] = sync2_q[gi] ^ cfg_q.polarity[gi];
        end
    endgenerate

    // pause state machine next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                // pulse-train motion is not ours to hold
                if (act[IN_PAUSE] && !seq.pulse_train &&
                    (seq.motion_active || seq.start_cmd)) begin
                    state_d = seq.line_writing ? ST_DRAIN : ST_PAUSED;
                end
            end
            ST_DRAIN: begin
                // let the program line finish first
                if (seq.alarm || act[IN_HALT]) begin
                    state_d = ST_CANCEL;
                end else if (!seq.line_writing) begin
                    state_d = ST_PAUSED;
                end
            end
            ST_PAUSED: begin
                if (seq.alarm || act[IN_HALT]) begin
                    state_d = ST_CANCEL;
                end else if (!act[IN_PAUSE]) begin
                    state_d = ST_RUN;
                end
            end
            ST_CANCEL: begin
                // release only rearms, never resumes
                if (!act[IN_PAUSE]) begin
                    state_d = ST_RUN;
                end
            end
        endcase
    end

    // pause state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // motion control outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            hold_decel <= 1'b0;
            exec_suspend <= 1'b0;
            resume_pulse <= 1'b0;
        end else begin
            // busy stays closed while held, opens on cancel
            busy <= (state_d == ST_PAUSED) || (state_d == ST_DRAIN) ||
                (seq.motion_active && state_d != ST_CANCEL);
            hold_decel <= (state_d == ST_PAUSED) && seq.motion_active;
            exec_suspend <= (state_d == ST_PAUSED);
            resume_pulse <= (state_q == ST_PAUSED) && (state_d == ST_RUN);
        end
    end

    // velocity override, ramp stays with the programmed profile
    // a full divide each cycle: costs area, saves a pipeline stage
    assign vel_prod = programmed_velocity * cfg_q.override_ratio;
    assign vel_scaled = vel_prod / {16'h0000, PCT_100};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_velocity <= '0;
        end else if (act[IN_OVR] && seq.motion_active && !seq.pulse_train) begin
            // only the target moves; accel/decel untouched
            if (vel_scaled > {16'h0000, VEL_MAX}) begin
                target_velocity <= VEL_MAX;
            end else begin
                target_velocity <= vel_scaled[15:0];
            end
        end else begin
            target_velocity <= programmed_velocity;
        end
    end

    // integral suppress and gain lowering
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            integral_ratio <= PCT_100;
            gain_ratio <= PCT_100;
        end else begin
            // limiter of zero gives zero integral at once
            integral_ratio <= act[IN_ISUP] ? cfg_q.observer_limiter_ratio : PCT_100;
            gain_ratio <= (act[IN_ISUP] && !seq.auto_tuning_command) ?
                cfg_q.gain_lowering_ratio : PCT_100;
        end
    end

    // homing start edge and proximity
    // mode codes live in the package so the decode has no magic values
    assign mode_uses_prox = (cfg_q.homing_mode == HMODE_PROX_1) || (cfg_q.homing_mode == HMODE_PROX_3) ||
        (cfg_q.homing_mode == HMODE_PROX_4) || (cfg_q.homing_mode == HMODE_PROX_5);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hstart_prev_q <= 1'b0;
            homing_go <= 1'b0;
            homing_mode_out <= '0;
            home_near <= 1'b0;
        end else begin
            hstart_prev_q <= act[IN_HSTART];
            // falling edge does nothing; readiness is the master's job
            homing_go <= act[IN_HSTART] && !hstart_prev_q;
            homing_mode_out <= cfg_q.homing_mode;
            home_near <= act[IN_HPROX] && mode_uses_prox;
        end
    end

    // origin tracking and warning
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            homed_q <= 1'b0;
            warn_origin_undefined <= 1'b0;
        end else begin
            if (seq.homing_done) begin
                homed_q <= 1'b1;
            end else if (seq.homing_abort) begin
                homed_q <= 1'b0;
            end
            // warning set wins over clearing by a finished homing
            if (seq.abs_move_cmd && !homed_q) begin
                warn_origin_undefined <= 1'b1;
            end else if (seq.homing_done) begin
                warn_origin_undefined <= 1'b0;
            end
        end
    end

    // event pulses for the interrupt status
    assign ev[EV_PAUSE] = (state_q != ST_PAUSED) && (state_d == ST_PAUSED);
    assign ev[EV_CANCEL] = (state_q != ST_CANCEL) && (state_d == ST_CANCEL);
    assign ev[EV_HOME] = act[IN_HSTART] && !hstart_prev_q;
    assign ev[EV_A5] = seq.abs_move_cmd && !homed_q;

    // apb decode: one wait state so data is registered
    // unmapped offsets raise the slave error and read as zero
    assign apb_acc = psel && penable && !pready;
    assign apb_wr = apb_acc && pwrite;
    assign apb_rd = apb_acc && !pwrite;
    always_comb begin
        rd_d = '0;
        hit = 1'b1;
        unique case (paddr)
            OFF_CTRL: rd_d = {21'h000000, cfg_q.homing_mode, 2'h0, cfg_q.polarity};
            OFF_OVR: rd_d = {16'h0000, cfg_q.override_ratio};
            OFF_GAIN: rd_d = {cfg_q.observer_limiter_ratio, cfg_q.gain_lowering_ratio};
            OFF_STAT: rd_d = {23'h000000, homed_q, warn_origin_undefined, busy, state_q, act[IN_HPROX],
                act[IN_PAUSE]};
            OFF_IRQ: rd_d = {28'h0000000, irq_stat_q};
            OFF_MASK: rd_d = {28'h0000000, irq_mask_q};
            default: hit = 1'b0;
        endcase
    end

    // bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= apb_acc;
            pslverr <= apb_acc && !hit;
            prdata <= apb_rd ? rd_d : 32'h00000000;
        end
    end

    // configuration registers, ratios clamped to range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q.polarity <= '0;
            cfg_q.homing_mode <= '0;
            cfg_q.override_ratio <= PCT_100;
            cfg_q.gain_lowering_ratio <= GAIN_LOWER_RST;
            cfg_q.observer_limiter_ratio <= LIMITER_RST;
            irq_mask_q <= '0;
        end else if (apb_wr) begin
            if (paddr == OFF_CTRL) begin
                cfg_q.polarity <= pwdata[IN_W-1:0];
                cfg_q.homing_mode <= pwdata[CTRL_MODE_LSB +: MODE_W];
            end
            if (paddr == OFF_OVR) begin
                cfg_q.override_ratio <= (pwdata[15:0] > PCT_200) ? PCT_200 : pwdata[15:0];
            end
            if (paddr == OFF_GAIN) begin
                cfg_q.gain_lowering_ratio <= (pwdata[15:0] > PCT_100) ? PCT_100 : pwdata[15:0];
                cfg_q.observer_limiter_ratio <= (pwdata[31:16] > PCT_100) ? PCT_100 : pwdata[31:16];
            end
            if (paddr == OFF_MASK) begin
                irq_mask_q <= pwdata[EV_W-1:0];
            end
        end
    end

    // sticky events, read clears, new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
        end else if (apb_rd && paddr == OFF_IRQ) begin
            irq_stat_q <= ev;
        end else begin
            irq_stat_q <= irq_stat_q | ev;
        end
    end

    // level interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // pause entry and the line drain
    pulse_ignored_a: assert property (seq.pulse_train && state_q == ST_RUN |=> state_q == ST_RUN)
        else $error("pause taken under pulse train");
    pause_entry_a: assert property (state_q == ST_RUN && act[IN_PAUSE] && seq.motion_active &&
        !seq.pulse_train && !seq.line_writing |=> hold_decel && exec_suspend && busy)
        else $error("pause did not stop internal motion");
    line_drain_a: assert property (state_q == ST_DRAIN && seq.line_writing &&
        !seq.alarm && !act[IN_HALT] |=> state_q == ST_DRAIN)
        else $error("paused before line finished");
    start_held_a: assert property (state_q == ST_RUN && act[IN_PAUSE] && seq.start_cmd &&
        !seq.pulse_train && !seq.line_writing |=> busy && exec_suspend)
        else $error("start while paused not held");

    // busy and suspension while held
    // busy and state load on one edge, so these need no delay
    busy_held_a: assert property (state_q == ST_PAUSED |-> busy)
        else $error("busy open while paused");
    suspend_held_a: assert property (state_q == ST_PAUSED |-> exec_suspend)
        else $error("execution not suspended while paused");
    cancel_busy_a: assert property (state_q == ST_PAUSED && (seq.alarm || act[IN_HALT])
        |=> !busy && !resume_pulse)
        else $error("cancel did not open busy");
    cancel_quiet_a: assert property (state_q == ST_CANCEL |=> !resume_pulse)
        else $error("resume after cancelled pause");
    resume_edge_a: assert property (state_q == ST_PAUSED && !act[IN_PAUSE] &&
        !seq.alarm && !act[IN_HALT] |=> resume_pulse)
        else $error("no resume after release");

    // velocity override and loop gains
    vel_pass_a: assert property (!act[IN_OVR] |=> target_velocity == $past(programmed_velocity))
        else $error("velocity changed without override");
    vel_clamp_a: assert property (act[IN_OVR] && seq.motion_active && !seq.pulse_train
        |=> target_velocity <= VEL_MAX)
        else $error("override velocity above limit");
    gain_tuning_a: assert property ($past(seq.auto_tuning_command) |-> gain_ratio == PCT_100)
        else $error("gain lowered during auto tuning");
    gain_lower_a: assert property (act[IN_ISUP] && !seq.auto_tuning_command
        |=> gain_ratio == $past(cfg_q.gain_lowering_ratio))
        else $error("gain not lowered");
    integral_cut_a: assert property ($past(act[IN_ISUP])
        |-> integral_ratio == $past(cfg_q.observer_limiter_ratio))
        else $error("integral not limited");
    loop_restore_a: assert property (!act[IN_ISUP]
        |=> integral_ratio == PCT_100 && gain_ratio == PCT_100)
        else $error("loop gains not restored");

    // homing start, proximity and origin
    home_edge_a: assert property (homing_go |-> $past(act[IN_HSTART]) && !$past(hstart_prev_q))
        else $error("homing start without rising edge");
    prox_mode_a: assert property (home_near |-> $past(act[IN_HPROX]) && $past(mode_uses_prox))
        else $error("proximity used in wrong mode");
    warn_a5_a: assert property (seq.abs_move_cmd && !homed_q |=> warn_origin_undefined)
        else $error("origin warning missing");
endmodule : sxci_top

/* File: sxci_pkg.sv */
package sxci_pkg;
    // input bit positions in the synchronised input vector
    localparam int IN_W = 6;
    localparam int IN_PAUSE = 0;
    localparam int IN_OVR = 1;
    localparam int IN_ISUP = 2;
    localparam int IN_HSTART = 3;
    localparam int IN_HPROX = 4;
    localparam int IN_HALT = 5;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_OVR = 8'h04;
    localparam logic [7:0] OFF_GAIN = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0c;
    localparam logic [7:0] OFF_IRQ = 8'h10;
    localparam logic [7:0] OFF_MASK = 8'h14;
    // ratios in 0.01 percent steps
    localparam logic [15:0] PCT_100 = 16'h2710;
    localparam logic [15:0] PCT_200 = 16'h4e20;
    localparam logic [15:0] GAIN_LOWER_RST = 16'h1388;
    localparam logic [15:0] LIMITER_RST = 16'h0000;
    // velocities in milli-rev per second, limit 10 rev/s
    localparam logic [15:0] VEL_MAX = 16'h2710;
    // ctrl field layout
    localparam int CTRL_MODE_LSB = 8;
    localparam int MODE_W = 3;
    // homing modes that follow the proximity input
    localparam logic [MODE_W-1:0] HMODE_PROX_1 = 3'h1;
    localparam logic [MODE_W-1:0] HMODE_PROX_3 = 3'h3;
    localparam logic [MODE_W-1:0] HMODE_PROX_4 = 3'h4;
    localparam logic [MODE_W-1:0] HMODE_PROX_5 = 3'h5;
    // irq event bits
    localparam int EV_W = 4;
    localparam int EV_PAUSE = 0;
    localparam int EV_CANCEL = 1;
    localparam int EV_HOME = 2;
    localparam int EV_A5 = 3;

    // software configuration travelling as one bundle
    typedef struct packed {
        logic [IN_W-1:0] polarity;
        logic [MODE_W-1:0] homing_mode;
        logic [15:0] override_ratio;
        logic [15:0] gain_lowering_ratio;
        logic [15:0] observer_limiter_ratio;
    } sxci_cfg_type;

    // sequencer handshake bundle, same clock domain
    typedef struct packed {
        logic motion_active;
        logic pulse_train;
        logic line_writing;
        logic start_cmd;
        logic abs_move_cmd;
        logic homing_done;
        logic homing_abort;
        logic auto_tuning_command;
        logic alarm;
    } sxci_seq_type;

    // pause state machine, one-hot
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_DRAIN = 4'h2,
        ST_PAUSED = 4'h4,
        ST_CANCEL = 4'h8
    } sxci_state_type;
endpackage : sxci_pkg

/* File: sxci_ctrl_model.sv */
`timescale 1ns/1ns
// master controller model: drives the discrete control pins
module sxci_ctrl_model (
    input wire logic pclk,
    input wire logic busy,
    input wire logic alarm,
    output logic [sxci_pkg::IN_W-1:0] pins
);
    import sxci_pkg::*;
    // all pins idle at time zero
    initial pins = '0;
    // pins change only just after a rising edge
    task automatic set_pin(input int idx, input logic v);
        @(posedge pclk);
        pins[idx] <= v;
    endtask : set_pin
    // homing start raised once the device is idle, healthy and not halted, or anyway after 100 cycles of waiting (ok then 0)
    task automatic home_start(output logic ok);
        int n;
        n = 0;
        while ((busy !== 1'b0 || alarm !== 1'b0 || pins[IN_HALT] !== 1'b0) && n < 100) begin
            @(posedge pclk);
            n++;
        end
        ok = (n < 100);
        @(posedge pclk);
        pins[IN_HSTART] <= 1'b1;
    endtask : home_start
endmodule : sxci_ctrl_model

/* File: sxci_top_tb.sv */
`timescale 1ns/1ns
// self-checking bench for the extended control inputs
module sxci_top_tb;
    import sxci_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ok, a, b;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [IN_W-1:0] pins;
    sxci_seq_type seq;
    logic [15:0] prog_vel, target_velocity, integral_ratio, gain_ratio;
    logic busy, hold_decel, exec_suspend, resume_pulse, homing_go, home_near, warn, irq;
    logic [2:0] hmode;
    int mismatches, checks, resumes, gos, r0;

    sxci_top sxci_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pause_request(pins[IN_PAUSE]), .speed_override_request(pins[IN_OVR]),
        .integral_suppress(pins[IN_ISUP]), .homing_start(pins[IN_HSTART]),
        .home_proximity_sensor(pins[IN_HPROX]), .halt_request(pins[IN_HALT]), .seq(seq),
        .programmed_velocity(prog_vel), .busy(busy), .hold_decel(hold_decel),
        .exec_suspend(exec_suspend), .resume_pulse(resume_pulse), .target_velocity(target_velocity),
        .integral_ratio(integral_ratio), .gain_ratio(gain_ratio), .homing_go(homing_go),
        .homing_mode_out(hmode), .home_near(home_near), .warn_origin_undefined(warn), .irq(irq));
    sxci_ctrl_model sxci_ctrl_model_inst (.pclk(pclk), .busy(busy), .alarm(seq.alarm), .pins(pins));

    // 125 MHz clock
    initial pclk = 1'b0;
    always #4 pclk = ~pclk;
    // count one-cycle pulses so none is missed between samples
    always @(posedge pclk) begin
        if (resume_pulse === 1'b1) resumes++;
        if (homing_go === 1'b1) gos++;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    // one apb transfer; waits for pready with a bound
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50) mismatches++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // one-cycle pulse on a sequencer bit (5 start, 4 abs move, 2 abort)
    task automatic pulse(input int i);
        @(posedge pclk);
        seq[i] <= 1'b1;
        @(posedge pclk);
        seq[i] <= 1'b0;
    endtask : pulse
    task automatic pin(input int i, input logic v);
        sxci_ctrl_model_inst.set_pin(i, v);
    endtask : pin
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        mismatches++;
        complete_run();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        seq = '0;
        prog_vel = 16'h07d0;
        cyc(6);
        presetn <= 1'b1;
        chk(32'(integral_ratio), 32'h2710);
        apb(0, OFF_OVR, 0);
        chk(rd, 32'h2710);
        apb(0, OFF_GAIN, 0);
        chk(rd, 32'h1388);
        apb(1, 8'h18, 32'h1);
        chk(32'(err), 1);
        apb(1, OFF_OVR, 32'hffff);
        apb(0, OFF_OVR, 0);
        chk(rd, 32'(PCT_200));
        // override at 150 percent: 2 rev/s becomes 3, 8 rev/s clamps at 10
        apb(1, OFF_OVR, 32'h3a98);
        seq.motion_active <= 1'b1;
        pin(IN_OVR, 1'b1);
        cyc(5);
        chk(32'(target_velocity), 32'h0bb8);
        prog_vel <= 16'h1f40;
        cyc(3);
        chk(32'(target_velocity), 32'(VEL_MAX));
        pin(IN_OVR, 1'b0);
        seq.motion_active <= 1'b0;
        // suppression: limiter zero cuts integral, gain lowered unless tuning
        apb(1, OFF_GAIN, 32'h0fa0);
        pin(IN_ISUP, 1'b1);
        cyc(5);
        chk(32'(integral_ratio), 0);
        chk(32'(gain_ratio), 32'h0fa0);
        apb(1, OFF_GAIN, 32'h0bb8_0fa0);
        cyc(3);
        chk(32'(integral_ratio), 32'h0bb8);
        seq.auto_tuning_command <= 1'b1;
        cyc(3);
        chk(32'(gain_ratio), 32'(PCT_100));
        seq.auto_tuning_command <= 1'b0;
        pin(IN_ISUP, 1'b0);
        // homing in mode 1: rising edge only, proximity with polarity
        apb(1, OFF_CTRL, 32'h100);
        cyc(1);
        chk(32'(hmode), 1);
        sxci_ctrl_model_inst.home_start(ok);
        chk(32'(ok), 1);
        cyc(5);
        chk(gos, 1);
        pin(IN_HSTART, 1'b0);
        cyc(5);
        chk(gos, 1);
        pin(IN_HPROX, 1'b1);
        cyc(5);
        chk(32'(home_near), 1);
        apb(1, OFF_CTRL, 32'h110);
        cyc(5);
        chk(32'(home_near), 0);
        apb(1, OFF_CTRL, 32'h200);
        cyc(3);
        chk(32'(home_near), 0);
        apb(1, OFF_CTRL, 32'h500);
        cyc(3);
        chk(32'(home_near), 1);
        apb(1, OFF_CTRL, 32'h100);
        pin(IN_HPROX, 1'b0);
        pulse(2);
        pulse(4);
        cyc(3);
        chk(32'(warn), 1);
        // pause during internal motion, interrupt, release
        seq.motion_active <= 1'b1;
        apb(1, OFF_MASK, 0);
        pin(IN_PAUSE, 1'b1);
        cyc(5);
        chk({busy, exec_suspend, hold_decel}, 3'b111);
        a = irq;
        apb(1, OFF_MASK, 32'hf);
        cyc(1);
        b = irq;
        chk(32'(a ^ b), 1);
        apb(0, OFF_IRQ, 0);
        chk(32'(rd[EV_PAUSE]), 1);
        apb(0, OFF_IRQ, 0);
        chk(32'(rd[EV_PAUSE]), 0);
        chk(32'(irq), 0);
        apb(1, OFF_MASK, 0);
        r0 = resumes;
        pin(IN_PAUSE, 1'b0);
        cyc(5);
        chk(resumes, r0 + 1);
        // halt cancels the pause; release then resumes nothing
        pin(IN_PAUSE, 1'b1);
        cyc(5);
        pin(IN_HALT, 1'b1);
        cyc(5);
        chk(32'(busy), 0);
        apb(0, OFF_STAT, 0);
        chk(32'(rd[5:2]), 8);
        pin(IN_PAUSE, 1'b0);
        pin(IN_HALT, 1'b0);
        cyc(5);
        chk(resumes, r0 + 1);
        // an alarm cancels the pause in the same way
        pin(IN_PAUSE, 1'b1);
        cyc(5);
        seq.alarm <= 1'b1;
        cyc(3);
        chk(32'(busy), 0);
        seq.alarm <= 1'b0;
        pin(IN_PAUSE, 1'b0);
        cyc(5);
        chk(resumes, r0 + 1);
        // pulse-train motion ignores pause
        seq.pulse_train <= 1'b1;
        pin(IN_PAUSE, 1'b1);
        cyc(5);
        apb(0, OFF_STAT, 0);
        chk({28'h0, rd[5:2]}, 1);
        chk(32'(exec_suspend), 0);
        pin(IN_PAUSE, 1'b0);
        seq.pulse_train <= 1'b0;
        // program line being written finishes first
        seq.line_writing <= 1'b1;
        pin(IN_PAUSE, 1'b1);
        cyc(5);
        apb(0, OFF_STAT, 0);
        chk(32'(rd[5:2]), 2);
        seq.line_writing <= 1'b0;
        cyc(3);
        apb(0, OFF_STAT, 0);
        chk(32'(rd[5:2]), 4);
        pin(IN_PAUSE, 1'b0);
        cyc(5);
        // start command while pause is held
        seq.motion_active <= 1'b0;
        pin(IN_PAUSE, 1'b1);
        cyc(5);
        pulse(5);
        cyc(3);
        chk({busy, exec_suspend}, 2'b11);
        pin(IN_PAUSE, 1'b0);
        cyc(5);
        complete_run();
    end
endmodule : sxci_top_tb
